//--- pkg/io_cmd_pkg.sv
// constants, types and helpers for the byte command port controller
package io_cmd_pkg;
  localparam int PORTS = 3;
  localparam int LINES = 8;
  localparam int NPINS = 24;
  // command characters
  localparam logic [7:0] OP_IDENT = 8'h3F;
  localparam logic [7:0] OP_WR_A = 8'h41;
  localparam logic [7:0] OP_RD_A = 8'h61;
  localparam logic [7:0] OP_DIR = 8'h21;
  localparam logic [7:0] OP_PULL = 8'h23;
  localparam logic [7:0] OP_THR = 8'h40;
  localparam logic [7:0] OP_SCHM = 8'h24;
  localparam logic [7:0] OP_HIGH = 8'h48;
  localparam logic [7:0] OP_LOW = 8'h4C;
  localparam logic [7:0] OP_MODE1 = 8'h31;
  localparam logic [7:0] OP_MODE2 = 8'h32;
  localparam logic [7:0] PIN_LAST = 8'h17;
  localparam logic [1:0] PORT_NONE = 2'h3;
  // identification reply, value arbitrary
  localparam int ID_LEN = 7;
  localparam logic [55:0] ID_TEXT = 56'h504F52544354_4C;
  localparam logic [2:0] ID_LAST = 3'h6;
  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h04;
  localparam logic [7:0] REG_ENABLE = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [7:0] REG_STATE = 8'h10;
  // event bits
  localparam int EVT_W = 3;
  localparam int EVT_BAD = 0;
  localparam int EVT_CHG = 1;
  localparam int EVT_RPT = 2;
  localparam int CTRL_RUN = 0;
  // reset values
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [23:0] DIR_RESET = 24'hFFFFFF;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PORT = 3'b001,
    ST_DATA = 3'b010,
    ST_PIN = 3'b011,
    ST_DES = 3'b100,
    ST_VAL = 3'b101,
    ST_ID = 3'b110
  } cmd_state_t;
  typedef enum logic [2:0] {
    CFG_LATCH = 3'b000,
    CFG_DIR = 3'b001,
    CFG_PULL = 3'b010,
    CFG_THR = 3'b011,
    CFG_SCHM = 3'b100
  } cfg_kind_t;
  // port number of a letter counted from base, PORT_NONE if none
  function automatic logic [1:0] port_of(input logic [7:0] c, input logic [7:0] base);
    logic [7:0] d;
    d = c - base;
    return (d < 8'h03) ? d[1:0] : PORT_NONE;
  endfunction
  // one character of the identification reply
  function automatic logic [7:0] id_char(input logic [2:0] idx);
    logic [55:0] t;
    t = ID_TEXT << {idx, 3'b000};
    return t[55:48];
  endfunction
endpackage

//--- pkg/io_core_if.sv
// signals shared between the controller and its helper modules
`timescale 1ns/1ps
interface io_core_if;
  logic [23:0] pins_q; // synchronised line levels
  logic [23:0] pins_chg; // one-cycle change marks
  logic [2:0] evt; // event pulses
  logic [3:0] state_code; // mode and command state
  logic run_en; // interpreter enable
  modport sync_side (output pins_q, output pins_chg);
  modport reg_side (input evt, input state_code, output run_en);
  modport main_side (input pins_q, input pins_chg, output evt, output state_code,
    input run_en);
endinterface

//--- core/pin_sync.sv
// two-stage synchroniser and change detector for the port lines
`timescale 1ns/1ps
module pin_sync
  import io_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [23:0] pins_in,
  io_core_if.sync_side core
);
  logic [23:0] meta_reg, meta_next; // first stage, read only by second
  logic [23:0] sync_reg, sync_next; // second stage
  logic [23:0] prev_reg, prev_next; // last seen level
  logic [2:0] prime_reg, prime_next; // fills with ones over the first loads
  // next values
  always_comb begin
    meta_next = pins_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
    prime_next = {prime_reg[1:0], 1'b1};
  end
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= CFG_RESET;
      sync_reg <= CFG_RESET;
      prev_reg <= CFG_RESET;
      prime_reg <= 3'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      prime_reg <= prime_next;
    end
  end
  assign core.pins_q = sync_reg;
  // change marks per port, held off until the stages hold real levels
  // so the first load after reset is not taken for a line change;
  // only that first load is masked; a later line change is still reported
  for (genvar p = 0; p < PORTS; p++) begin : g_chg
    assign core.pins_chg[p*LINES +: LINES] = (sync_reg[p*LINES +: LINES]
      ^ prev_reg[p*LINES +: LINES]) & {LINES{prime_reg[2]}};
  end
endmodule // pin_sync

//--- core/ahb_regs.sv
// ahb-lite register slave with sticky event status and interrupt
`timescale 1ns/1ps
module ahb_regs
  import io_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  io_core_if.reg_side core
);
  logic wr_reg, wr_next; // write data phase pending
  logic [7:0] addr_reg, addr_next; // latched offset
  logic [31:0] rdata_reg, rdata_next; // read data
  logic [2:0] status_reg, status_next; // sticky events
  logic [2:0] enable_reg, enable_next; // interrupt enables
  logic run_reg, run_next; // interpreter enable
  logic take; // address phase accepted
  assign take = hsel && hready && htrans[1];
  // next values
  always_comb begin
    wr_next = take && hwrite;
    addr_next = take ? haddr[7:0] : addr_reg;
    rdata_next = rdata_reg;
    enable_next = enable_reg;
    run_next = run_reg;
    status_next = status_reg;
    // data phase write, unmapped offsets ignored
    if (wr_reg) begin
      case (addr_reg)
        REG_CLEAR: status_next = status_reg & ~hwdata[2:0];
        REG_ENABLE: enable_next = hwdata[2:0];
        REG_CTRL: run_next = hwdata[CTRL_RUN];
        default: ;
      endcase
    end
    // new events win over a clear
    status_next = status_next | core.evt;
    // read data ready for the data phase
    if (take && !hwrite) begin
      case (haddr[7:0])
        REG_STATUS: rdata_next = {29'h0, status_reg};
        REG_ENABLE: rdata_next = {29'h0, enable_reg};
        REG_CTRL: rdata_next = {31'h0, run_reg};
        REG_STATE: rdata_next = {28'h0, core.state_code};
        default: rdata_next = 32'h0;
      endcase
    end
  end
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0;
      status_reg <= 3'h0;
      enable_reg <= 3'h0;
      run_reg <= CTRL_RESET;
    end else begin
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      status_reg <= status_next;
      enable_reg <= enable_next;
      run_reg <= run_next;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign irq = |(status_reg & enable_reg);
  assign core.run_en = run_reg;
endmodule // ahb_regs

//--- core/io_cmd_top.sv
// byte command interpreter driving three 8-line ports
// What this block does
// - opcodes are printable characters, decoded by code
// - data bytes are raw binary, one per write
// - lowercase read letter returns one port byte
// - '!' port letter byte loads direction mask
// - direction bit one is input, zero output
// - first line is weight one, eighth weight 128
// - 'H'/'L' with index drives one line
// - '#' prefix write sets pull-up enables
// - '@' prefix write selects input threshold
// - '$' prefix write sets schmitt enables
// - '2' enters change reporting, '1' leaves
// - change mode reports input changes unasked
// - change mode replies carry port letter first
// - change mode reports port after changing write, if the port has an output line
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module io_cmd_top
  import io_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  input wire logic [23:0] io_in,
  output logic [23:0] io_out,
  output logic [23:0] io_oe,
  output logic [23:0] pull_en,
  output logic [23:0] ttl_sel,
  output logic [23:0] schmitt_en
);
  io_core_if core ();

  // line synchroniser
  pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins_in(io_in),
    .core(core.sync_side)
  );

  // register slave; hsize is always a word here
  ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .irq(irq),
    .core(core.reg_side)
  );

  cmd_state_t state_reg, state_next; // interpreter state
  cfg_kind_t kind_reg, kind_next; // target of a data byte
  logic [1:0] port_reg, port_next; // selected port
  logic [2:0] idx_reg, idx_next; // identification position
  logic [23:0] latch_reg, latch_next; // output latches
  logic [23:0] dir_reg, dir_next; // direction masks
  logic [23:0] pull_reg, pull_next; // pull-up enables
  logic [23:0] thr_reg, thr_next; // threshold select
  logic [23:0] schm_reg, schm_next; // schmitt enables
  logic mode2_reg, mode2_next; // change reporting mode
  logic [2:0] pend_reg, pend_next; // ports awaiting a report
  logic [7:0] txd_reg, txd_next; // outgoing byte
  logic txv_reg, txv_next; // outgoing byte valid

  logic [23:0] port_val; // visible level of each line
  logic [2:0] pend_set; // input change per port
  logic [2:0] pend_clr; // report started per port
  logic [2:0] evt; // event pulses
  logic rx_take; // byte accepted this cycle
  logic tx_done; // byte handed over this cycle
  logic report_go; // report may start now
  logic [1:0] wr_port; // port of a write letter
  logic [1:0] rd_port; // port of a read letter
  logic [1:0] low_pend; // lowest pending port
  logic [4:0] base; // first line of selected port

  // inputs read the pin, outputs read their latch
  assign port_val = (dir_reg & core.pins_q) | (~dir_reg & latch_reg);

  // input changes per port mark a pending report
  for (genvar p = 0; p < PORTS; p++) begin : g_pend
    assign pend_set[p] = |(core.pins_chg[p*LINES +: LINES]
      & dir_reg[p*LINES +: LINES]);
  end

  assign wr_port = port_of(rx_data, OP_WR_A);
  assign rd_port = port_of(rx_data, OP_RD_A);
  assign low_pend = pend_reg[0] ? 2'h0 : (pend_reg[1] ? 2'h1 : 2'h2);
  assign base = {port_reg, 3'b000};
  assign report_go = mode2_reg && (|pend_reg) && core.run_en;
  assign tx_done = txv_reg && tx_ready;

  // bytes are taken only while waiting for input
  always_comb begin
    rx_ready = 1'b0;
    if (core.run_en) begin
      case (state_reg)
        ST_IDLE: rx_ready = !report_go;
        ST_PORT, ST_DATA, ST_PIN: rx_ready = 1'b1;
        default: rx_ready = 1'b0;
      endcase
    end
  end
  assign rx_take = rx_valid && rx_ready;

  // interpreter next state
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    port_next = port_reg;
    idx_next = idx_reg;
    latch_next = latch_reg;
    dir_next = dir_reg;
    pull_next = pull_reg;
    thr_next = thr_reg;
    schm_next = schm_reg;
    mode2_next = mode2_reg;
    txd_next = txd_reg;
    txv_next = txv_reg && !tx_done;
    pend_clr = 3'h0;
    evt = 3'h0;
    evt[EVT_CHG] = |pend_set;
    case (state_reg)
      // waiting for an opcode
      ST_IDLE: begin
        if (report_go) begin
          // unasked report, designator first
          port_next = low_pend;
          pend_clr[low_pend] = 1'b1;
          txd_next = OP_RD_A + {6'h00, low_pend};
          txv_next = 1'b1;
          state_next = ST_DES;
        end else if (rx_take) begin
          case (rx_data)
            OP_IDENT: begin
              // identification text
              idx_next = 3'h0;
              txd_next = id_char(3'h0);
              txv_next = 1'b1;
              state_next = ST_ID;
            end
            OP_MODE2: mode2_next = 1'b1;
            OP_MODE1: mode2_next = 1'b0;
            OP_DIR: begin
              kind_next = CFG_DIR;
              state_next = ST_PORT;
            end
            OP_PULL: begin
              kind_next = CFG_PULL;
              state_next = ST_PORT;
            end
            OP_THR: begin
              kind_next = CFG_THR;
              state_next = ST_PORT;
            end
            OP_SCHM: begin
              kind_next = CFG_SCHM;
              state_next = ST_PORT;
            end
            OP_HIGH, OP_LOW: begin
              // remember the level in the kind bit
              kind_next = (rx_data == OP_HIGH) ? CFG_DIR : CFG_LATCH;
              state_next = ST_PIN;
            end
            default: begin
              if (wr_port != PORT_NONE) begin
                // plain port write
                kind_next = CFG_LATCH;
                port_next = wr_port;
                state_next = ST_DATA;
              end else if (rd_port != PORT_NONE) begin
                // port read, designator first in change mode
                port_next = rd_port;
                txv_next = 1'b1;
                if (mode2_reg) begin
                  txd_next = rx_data;
                  state_next = ST_DES;
                end else begin
                  txd_next = port_val[{rd_port, 3'b000} +: 8];
                  state_next = ST_VAL;
                end
              end else begin
                evt[EVT_BAD] = 1'b1;
              end
            end
          endcase
        end
      end
      // port letter after a prefix
      ST_PORT: begin
        if (rx_take) begin
          if (wr_port != PORT_NONE) begin
            port_next = wr_port;
            state_next = ST_DATA;
          end else begin
            evt[EVT_BAD] = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      // raw data byte for the chosen target
      ST_DATA: begin
        if (rx_take) begin
          case (kind_reg)
            CFG_DIR: dir_next[base +: 8] = rx_data;
            CFG_PULL: pull_next[base +: 8] = rx_data;
            CFG_THR: thr_next[base +: 8] = rx_data;
            CFG_SCHM: schm_next[base +: 8] = rx_data;
            default: latch_next[base +: 8] = rx_data;
          endcase
          state_next = ST_IDLE;
        end
      end
      // pin index for a single line
      ST_PIN: begin
        if (rx_take) begin
          if (rx_data <= PIN_LAST) begin
            latch_next[rx_data[4:0]] = (kind_reg == CFG_DIR);
          end else begin
            evt[EVT_BAD] = 1'b1;
          end
          state_next = ST_IDLE;
        end
      end
      // designator sent, now the port byte
      ST_DES: begin
        if (tx_done) begin
          txd_next = port_val[base +: 8];
          txv_next = 1'b1;
          state_next = ST_VAL;
        end
      end
      // port byte sent
      ST_VAL: begin
        if (tx_done) begin
          evt[EVT_RPT] = 1'b1;
          state_next = ST_IDLE;
        end
      end
      // identification text, one byte at a time
      ST_ID: begin
        if (tx_done) begin
          if (idx_reg == ID_LAST) begin
            state_next = ST_IDLE;
          end else begin
            idx_next = idx_reg + 3'h1;
            txd_next = id_char(idx_reg + 3'h1);
            txv_next = 1'b1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // pending reports: a new change wins over a clear
  always_comb begin
    pend_next = (pend_reg & ~pend_clr) | pend_set;
    // a latch change on a port with at least one output line reports it
    for (int p = 0; p < PORTS; p++) begin
      if ((latch_next[p*LINES +: LINES] != latch_reg[p*LINES +: LINES])
          && ((~dir_reg[p*LINES +: LINES]) != 8'h00)) begin
        pend_next[p] = 1'b1;
      end
    end
    if (!mode2_next) begin
      pend_next = 3'h0;
    end
  end

  // interpreter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      kind_reg <= CFG_LATCH;
      port_reg <= 2'h0;
      idx_reg <= 3'h0;
      latch_reg <= CFG_RESET;
      dir_reg <= DIR_RESET;
      pull_reg <= CFG_RESET;
      thr_reg <= CFG_RESET;
      schm_reg <= CFG_RESET;
      mode2_reg <= 1'b0;
      pend_reg <= 3'h0;
      txd_reg <= 8'h00;
      txv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      port_reg <= port_next;
      idx_reg <= idx_next;
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      pull_reg <= pull_next;
      thr_reg <= thr_next;
      schm_reg <= schm_next;
      mode2_reg <= mode2_next;
      pend_reg <= pend_next;
      txd_reg <= txd_next;
      txv_reg <= txv_next;
    end
  end

  // pin and configuration outputs
  assign io_out = latch_reg;
  assign io_oe = ~dir_reg;
  assign pull_en = pull_reg;
  assign ttl_sel = thr_reg;
  assign schmitt_en = schm_reg;
  assign tx_data = txd_reg;
  assign tx_valid = txv_reg;
  assign core.evt = evt;
  assign core.state_code = {mode2_reg, state_reg};
endmodule // io_cmd_top

//--- dv/io_cmd_top_properties.sv
// concurrent port checks for the byte command port controller
`timescale 1ns/1ps
module io_cmd_top_properties
  import io_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [23:0] io_out,
  input wire logic [23:0] io_oe,
  input wire logic [23:0] pull_en,
  input wire logic [23:0] ttl_sel,
  input wire logic [23:0] schmitt_en
);
  // one clock domain, checks off in reset
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // slave never stalls and never errors
  bus_answer_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with error");
  // read data moves only after a read address phase
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite))
    else $error("read data changed without a read");
  // interrupt drops only after a register write lands
  irq_clear_a: assert property ($fell(irq) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("interrupt dropped without a register write");
  // reply byte stands until the sink takes it
  reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped or changed before taken");
  // reply leaves only when the sink was ready
  reply_end_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
    else $error("reply withdrawn without sink ready");
  // no new command byte taken while a reply is out
  busy_block_a: assert property (tx_valid |-> !rx_ready)
    else $error("byte taken while a reply was pending");
  // port and config state moves only after a taken byte
  cfg_cause_a: assert property (!$past(rx_valid && rx_ready) |->
    $stable({io_out, io_oe, pull_en, ttl_sel, schmitt_en}))
    else $error("port state changed without a command byte");
  // a reply starts only after a taken byte or a held-off report
  reply_cause_a: assert property ($rose(tx_valid) |-> $past(rx_valid || !rx_ready))
    else $error("reply started without a cause");
endmodule // io_cmd_top_properties

//--- dv/host_model.sv
// host bridge model: command byte source and reply byte sink
`timescale 1ns/1ps
module host_model (
  input wire logic hclk,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic slow,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  logic [7:0] send_q[$]; // bytes queued by the bench
  logic [7:0] got_q[$]; // reply bytes received
  logic [7:0] last_b; // last byte handed over
  // idle lines at time zero
  initial begin
    rx_data = 8'hFF;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    last_b = 8'h00;
  end
  // source holds each byte until taken, sink stalls when slow
  always @(posedge hclk) begin
    if (rx_valid && rx_ready) begin
      last_b = send_q.pop_front();
    end
    if (send_q.size() > 0) begin
      rx_valid <= 1'b1;
      rx_data <= send_q[0];
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~last_b; // released line shows no stale value
    end
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule // host_model

//--- dv/test_byte_command_io_port_controller.sv
// self-checking bench for the byte command port controller
`timescale 1ns/1ps
module test_byte_command_io_port_controller;
  import io_cmd_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq; // bus control
  logic [31:0] haddr, hwdata, hrdata, rd; // bus words, last read
  logic [1:0] htrans; // transfer kind
  logic [2:0] hsize; // always a word
  logic [7:0] rx_data, tx_data; // byte stream
  logic rx_valid, rx_ready, tx_valid, tx_ready, slow; // stream handshakes
  logic [23:0] io_in, io_out, io_oe, pull_en, ttl_sel, schmitt_en; // port lines
  logic [55:0] id_exp; // expected identity text
  int num_errors;
  int checks;
  assign hready = hreadyout;
  io_cmd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .irq, .rx_data, .rx_valid, .rx_ready, .tx_data,
    .tx_ready, .tx_valid, .io_in, .io_out, .io_oe, .pull_en, .ttl_sel, .schmitt_en);
  host_model host_u (.hclk, .rx_ready, .tx_data, .tx_valid, .slow, .rx_data, .rx_valid,
    .tx_ready);
  // clock at 25 ns
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // verdict and end of run
  task automatic print_verdict;
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // word compare
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // compare next reply byte
  task automatic cmp_byte(input string nm, input logic [7:0] e);
    logic [7:0] g;
    g = (host_u.got_q.size() > 0) ? host_u.got_q.pop_front() : 8'hXX;
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // queue one stream byte
  task automatic put(input logic [7:0] b);
    host_u.send_q.push_back(b);
  endtask
  // wait for stream drained and n replies, bounded
  task automatic settle(input int n);
    int k;
    k = 0;
    while ((host_u.send_q.size() > 0 || host_u.got_q.size() < n) && k < 400) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 400) begin
      num_errors++;
      print_verdict();
    end
    repeat (4) @(posedge hclk);
  endtask
  // one single word transfer, read data into rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge hclk);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    rd = hrdata;
    if (k >= 50) begin
      num_errors++;
      print_verdict();
    end
    @(posedge hclk);
  endtask
  // main sequence
  initial begin
    {hresetn, hwrite, hwdata, haddr, htrans, slow, num_errors, checks} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    io_in = 24'h5A3C96;
    id_exp = "PORTCTL";
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmp_word("oe reset", 32'h0, {8'h00, io_oe | io_out | pull_en | ttl_sel | schmitt_en});
    ahb(1'b0, REG_CTRL, 32'h0);
    cmp_word("ctrl reset", 32'h1, rd);
    ahb(1'b0, 8'h20, 32'h0);
    cmp_word("unmapped", 32'h0, rd);
    ahb(1'b0, REG_STATUS, 32'h0);
    cmp_word("status reset", 32'h0, rd);
    for (int k = 0; k < 3; k++) begin
      put(OP_DIR);
      put(OP_WR_A + 8'(k));
      put((k == 0) ? 8'h0F : 8'h00);
      put(OP_WR_A + 8'(k));
      put(8'(24'h400281 >> (8 * k)));
    end
    put(OP_HIGH);
    put(PIN_LAST);
    put(OP_LOW);
    put(8'h00);
    put(OP_HIGH);
    put(8'h18);
    put("Z");
    settle(0);
    cmp_word("io_oe", 32'h00FFFFF0, {8'h00, io_oe});
    cmp_word("io_out", 32'h00C00280, {8'h00, io_out});
    for (int k = 0; k < 3; k++) begin
      put((k == 0) ? OP_PULL : (k == 1) ? OP_THR : OP_SCHM);
      put("B");
      put(8'(24'hC33CA5 >> (8 * k)));
    end
    put(OP_PULL);
    put("D");
    settle(0);
    cmp_word("pull_en", 32'h0000A500, {8'h00, pull_en});
    cmp_word("ttl_sel", 32'h00003C00, {8'h00, ttl_sel});
    cmp_word("schmitt_en", 32'h0000C300, {8'h00, schmitt_en});
    put("a");
    put("b");
    put("c");
    settle(3);
    cmp_byte("read a", (io_in[7:0] & 8'h0F) | 8'h80);
    cmp_byte("read b", 8'h02);
    cmp_byte("read c", 8'hC0);
    slow <= 1'b1;
    put(OP_IDENT);
    settle(7);
    for (int i = 0; i < 7; i++) begin
      cmp_byte("ident", id_exp[55 - 8 * i -: 8]);
    end
    slow <= 1'b0;
    put(OP_MODE2);
    settle(0);
    ahb(1'b0, REG_STATE, 32'h0);
    cmp_word("state", 32'h8, rd);
    put("b");
    settle(2);
    cmp_byte("tag b", 8'h62);
    cmp_byte("read b2", 8'h02);
    io_in <= io_in ^ 24'h000001;
    settle(2);
    cmp_byte("tag a", 8'h61);
    cmp_byte("change a", 8'h87);
    put("C");
    put(8'h41);
    settle(2);
    cmp_byte("tag c", 8'h63);
    cmp_byte("write c", 8'h41);
    put(OP_MODE1);
    put("a");
    settle(1);
    cmp_byte("read a1", 8'h87);
    ahb(1'b1, REG_CLEAR, 32'h7);
    ahb(1'b1, REG_ENABLE, 32'h1);
    put(8'h7E);
    settle(0);
    cmp_word("irq set", 32'h1, {31'h0, irq});
    ahb(1'b0, REG_STATUS, 32'h0);
    cmp_word("status", 32'h1, rd);
    ahb(1'b1, REG_ENABLE, 32'h0);
    cmp_word("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, REG_ENABLE, 32'h1);
    cmp_word("irq unmasked", 32'h1, {31'h0, irq});
    ahb(1'b1, REG_CLEAR, 32'h1);
    cmp_word("irq cleared", 32'h0, {31'h0, irq});
    ahb(1'b0, REG_STATUS, 32'h0);
    cmp_word("status clr", 32'h0, rd);
    ahb(1'b1, REG_CTRL, 32'h0);
    put("a");
    repeat (6) @(posedge hclk);
    cmp_word("run off", 32'h0, {31'h0, rx_ready});
    ahb(1'b1, REG_CTRL, 32'h1);
    settle(1);
    cmp_byte("read a2", 8'h87);
    cmp_word("replies", 32'h0, 32'(host_u.got_q.size()));
    print_verdict();
  end
endmodule // test_byte_command_io_port_controller

bind io_cmd_top io_cmd_top_properties chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hreadyout, .hresp, .hrdata, .irq, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready,
  .io_out, .io_oe, .pull_en, .ttl_sel, .schmitt_en);
